// *** lmac_pkg.sv ***
// Shared constants, register map and carrier types of the long-mode activation control block
package lmac_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] LMAC_CTRL_OFF = 8'h00;
    localparam logic [7:0] LMAC_CS_OFF = 8'h04;
    localparam logic [7:0] LMAC_PTB_LO_OFF = 8'h08;
    localparam logic [7:0] LMAC_PTB_HI_OFF = 8'h0c;
    localparam logic [7:0] LMAC_PFX_OFF = 8'h10;
    localparam logic [7:0] LMAC_MODE_OFF = 8'h14;
    localparam logic [7:0] LMAC_FAULT_OFF = 8'h18;
    localparam logic [7:0] LMAC_TBL_OFF = 8'h1c;

    // Field positions
    localparam int LMAC_LME_BIT = 0;
    localparam int LMAC_PG_BIT = 1;
    localparam int LMAC_PAE_BIT = 2;
    localparam int LMAC_LMA_BIT = 3;
    localparam int LMAC_CS_L_BIT = 0;
    localparam int LMAC_CS_D_BIT = 1;
    localparam int LMAC_PFX_OPSZ_BIT = 0;
    localparam int LMAC_PFX_W_BIT = 1;
    localparam int LMAC_PFX_ADSZ_BIT = 2;
    localparam int LMAC_FLT_STICKY_BIT = 0;
    localparam int LMAC_FLT_REFUSED_BIT = 1;
    localparam int LMAC_FLT_CNT_LSB = 8;
    localparam int LMAC_FLT_CODE_LSB = 16;
    localparam int LMAC_MODE_SUB_LSB = 0;
    localparam int LMAC_MODE_DADDR_LSB = 2;
    localparam int LMAC_MODE_DOP_LSB = 4;
    localparam int LMAC_MODE_EADDR_LSB = 6;
    localparam int LMAC_MODE_EOP_LSB = 8;
    localparam int LMAC_MODE_RSVD_BIT = 10;
    localparam int LMAC_MODE_F64_BIT = 11;
    localparam int LMAC_TBL_COUNT = 4;

    // Reset values and fixed codes
    localparam logic [2:0] LMAC_CTRL_RST = 3'h0;
    localparam logic [1:0] LMAC_CS_RST = 2'h0;
    localparam logic [2:0] LMAC_PFX_RST = 3'h0;
    localparam logic [63:0] LMAC_PTB_RST = 64'h0;
    localparam logic [15:0] LMAC_GP_ERROR_CODE = 16'h0000;
    localparam logic [7:0] LMAC_CNT_MAX = 8'hff;

    typedef enum logic [1:0] {
        LMAC_SUB_LEGACY = 2'b00,
        LMAC_SUB_COMPAT = 2'b01,
        LMAC_SUB_LONG64 = 2'b10,
        LMAC_SUB_RSVD = 2'b11
    } lmac_submode_t;

    typedef enum logic [1:0] {
        LMAC_SZ16 = 2'b00,
        LMAC_SZ32 = 2'b01,
        LMAC_SZ64 = 2'b10
    } lmac_size_t;

    typedef struct packed {
        logic phys_addr_extension_bit;
        logic paging_enable_bit;
        logic long_mode_enable_bit;
    } lmac_ctrl_t;

    typedef struct packed {
        logic def_size;
        logic long_attr;
    } lmac_cs_t;

    typedef struct packed {
        logic addr_ovr;
        logic op64;
        logic op_ovr;
    } lmac_pfx_t;

    typedef struct packed {
        lmac_submode_t submode;
        lmac_size_t def_addr;
        lmac_size_t def_op;
        lmac_size_t eff_addr;
        lmac_size_t eff_op;
        logic rsvd;
    } lmac_mode_t;

endpackage

// *** lmac_mode_decode.sv ***
// Submode and default/effective operand and address size decoder
`timescale 1ns/1ps
module lmac_mode_decode
    import lmac_pkg::*;
(
    input wire logic active,
    input wire lmac_cs_t cs,
    input wire lmac_pfx_t pfx,
    output lmac_mode_t mode
);

    // Legacy-style size from the default-size attribute, optionally toggled by a prefix
    function automatic lmac_size_t legacy_size(input logic d);
        return d ? LMAC_SZ32 : LMAC_SZ16;
    endfunction

    always_comb begin
        mode = '0;
        if (!active) begin
            // Long attribute ignored; nothing wider than 32 bits is reachable
            mode.submode = LMAC_SUB_LEGACY; // RL2
            mode.def_addr = legacy_size(cs.def_size); // RL7
            mode.def_op = legacy_size(cs.def_size); // RL7
            mode.eff_addr = legacy_size(cs.def_size ^ pfx.addr_ovr); // RL2
            mode.eff_op = legacy_size(cs.def_size ^ pfx.op_ovr); // RL2
        end else if (!cs.long_attr) begin
            mode.submode = LMAC_SUB_COMPAT; // RL6
            mode.def_addr = legacy_size(cs.def_size); // RL6
            mode.def_op = legacy_size(cs.def_size); // RL6
            mode.eff_addr = legacy_size(cs.def_size ^ pfx.addr_ovr);
            mode.eff_op = legacy_size(cs.def_size ^ pfx.op_ovr);
        end else if (!cs.def_size) begin
            mode.submode = LMAC_SUB_LONG64; // RL3
            mode.def_addr = LMAC_SZ64; // RL3
            mode.def_op = LMAC_SZ32; // RL3
            mode.eff_addr = pfx.addr_ovr ? LMAC_SZ32 : LMAC_SZ64; // RL4
            // Wide-operand prefix takes precedence over the 16-bit override
            mode.eff_op = pfx.op64 ? LMAC_SZ64 : (pfx.op_ovr ? LMAC_SZ16 : LMAC_SZ32); // RL4
        end else begin
            // Reserved encoding: flagged, sizes held at 32 so nothing undefined leaks out
            mode.submode = LMAC_SUB_RSVD; // RL5
            mode.rsvd = 1'b1; // RL5
            mode.def_addr = LMAC_SZ32;
            mode.def_op = LMAC_SZ32;
            mode.eff_addr = LMAC_SZ32;
            mode.eff_op = LMAC_SZ32;
        end
    end

endmodule

// *** lmac_long_mode_ctrl.sv ***
// Long-mode activation control with consistency checks, behind a classic Wishbone slave
`timescale 1ns/1ps
// Contract
// RL1: Setting long-mode enable alone does nothing; enabling paging with it set activates long mode.
// RL2: Until active, behave as a 32-bit processor and refuse all 64-bit features.
// RL3: Active, long attribute 1, size attribute 0: 64-bit submode, address 64, operand 32.
// RL4: In 64-bit submode prefixes give operand 64 or 16, address 32.
// RL5: Active with long 1 and size 1 is a reserved encoding.
// RL6: Active with long 0 is compatibility submode; size attribute picks 32 or 16.
// RL7: Inactive: long attribute ignored; size attribute picks 32 or 16 bits.
// RL8: Software clears paging, sets extensions, page base and enable, then sets paging.
// RL9: Software keeps paging writes and the following branch in identity-mapped pages.
// RL10: Every write to the three control bits is checked; failure faults with code 0.
// RL11: Changing long-mode enable while paging is on faults.
// RL12: Paging 0 to 1 with enable 1 and extensions 0 faults.
// RL13: Paging on with enable 1 and code long attribute 1 faults.
// RL14: Clearing extensions while long mode is active faults.
// RL15: A faulting write leaves control bits and the active flag unchanged.
// RL16: After activation table pointers stay legacy until software reloads them.
// RL17: Software blocks all interrupts and exceptions until the interrupt table is 64-bit.
// RL18: Software masks maskable interrupts; external hardware blocks the others.
// RL19: Page base writes in legacy mode update only the low 32 bits.
// RL20: Once active, software may rewrite the full page-table base.
// RL21: Clearing paging while active deactivates long mode and clears the flag.
module lmac_long_mode_ctrl
    import lmac_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic long_mode_active_flag,
    output logic feat64_allowed,
    output lmac_mode_t mode_o,
    output logic [63:0] page_table_base_reg,
    output logic general_protection_fault,
    output logic [15:0] gp_error_code
);

    // Byte-lane merge used by the control and page-base registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic ack_q;
    logic [31:0] dat_q;
    lmac_ctrl_t ctrl_q;
    logic lma_q;
    lmac_cs_t cs_q;
    lmac_pfx_t pfx_q;
    logic [63:0] ptb_q;
    logic gp_q;
    logic sticky_q;
    logic refused_q;
    logic [7:0] cnt_q;
    logic [LMAC_TBL_COUNT-1:0] tbl_q;
    lmac_mode_t mode_q;
    logic f64_q;

    logic req;
    logic wr;
    logic wr_ctrl;
    logic wr_cs;
    logic wr_pfx;
    logic wr_lo;
    logic wr_hi;
    logic wr_flt;
    logic wr_tbl;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_wdata;
    lmac_ctrl_t ctrl_new;
    logic lme_chg;
    logic pg_rise;
    logic pg_fall;
    logic pae_fall;
    logic chk_fail;
    logic lma_d;
    logic activate;
    logic deactivate;
    logic refuse;
    lmac_mode_t mode_d;
    logic [31:0] rd_mux;

    assign req = wb_cyc_i & wb_stb_i;
    // A write takes effect only at the edge where the master sees ack
    assign wr = req & wb_we_i & ack_q;
    assign wr_ctrl = wr & (wb_adr_i == LMAC_CTRL_OFF);
    assign wr_cs = wr & (wb_adr_i == LMAC_CS_OFF);
    assign wr_pfx = wr & (wb_adr_i == LMAC_PFX_OFF);
    assign wr_lo = wr & (wb_adr_i == LMAC_PTB_LO_OFF);
    assign wr_hi = wr & (wb_adr_i == LMAC_PTB_HI_OFF);
    assign wr_flt = wr & (wb_adr_i == LMAC_FAULT_OFF);
    assign wr_tbl = wr & (wb_adr_i == LMAC_TBL_OFF);

    // Consistency checks on the attempted control-bit values
    always_comb begin
        ctrl_word = '0;
        ctrl_word[LMAC_LME_BIT] = ctrl_q.long_mode_enable_bit;
        ctrl_word[LMAC_PG_BIT] = ctrl_q.paging_enable_bit;
        ctrl_word[LMAC_PAE_BIT] = ctrl_q.phys_addr_extension_bit;
        ctrl_word[LMAC_LMA_BIT] = lma_q;
        ctrl_wdata = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
        ctrl_new.long_mode_enable_bit = ctrl_wdata[LMAC_LME_BIT];
        ctrl_new.paging_enable_bit = ctrl_wdata[LMAC_PG_BIT];
        ctrl_new.phys_addr_extension_bit = ctrl_wdata[LMAC_PAE_BIT];
    end

    assign lme_chg = ctrl_new.long_mode_enable_bit != ctrl_q.long_mode_enable_bit;
    assign pg_rise = ctrl_new.paging_enable_bit & ~ctrl_q.paging_enable_bit;
    assign pg_fall = ~ctrl_new.paging_enable_bit & ctrl_q.paging_enable_bit;
    assign pae_fall = ~ctrl_new.phys_addr_extension_bit & ctrl_q.phys_addr_extension_bit;

    // Enable and extension bits are judged at their post-write values, so one write may set all three
    assign chk_fail = (lme_chg & ctrl_q.paging_enable_bit) // RL11
        | (pg_rise & ctrl_new.long_mode_enable_bit & ~ctrl_new.phys_addr_extension_bit) // RL12
        | (pg_rise & ctrl_new.long_mode_enable_bit & cs_q.long_attr) // RL13
        | (pae_fall & lma_q); // RL14

    assign activate = wr_ctrl & ~chk_fail & pg_rise & ctrl_new.long_mode_enable_bit; // RL1
    assign deactivate = wr_ctrl & ~chk_fail & pg_fall & lma_q; // RL21

    always_comb begin
        lma_d = lma_q;
        if (activate) begin
            lma_d = 1'b1; // RL1
        end else if (deactivate) begin
            lma_d = 1'b0; // RL21
        end
    end

    // Wishbone handshake: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (wb_adr_i)
            LMAC_CTRL_OFF: begin
                rd_mux = ctrl_word;
            end
            LMAC_CS_OFF: begin
                rd_mux[LMAC_CS_L_BIT] = cs_q.long_attr;
                rd_mux[LMAC_CS_D_BIT] = cs_q.def_size;
            end
            LMAC_PTB_LO_OFF: begin
                rd_mux = ptb_q[31:0];
            end
            LMAC_PTB_HI_OFF: begin
                rd_mux = ptb_q[63:32];
            end
            LMAC_PFX_OFF: begin
                rd_mux[LMAC_PFX_OPSZ_BIT] = pfx_q.op_ovr;
                rd_mux[LMAC_PFX_W_BIT] = pfx_q.op64;
                rd_mux[LMAC_PFX_ADSZ_BIT] = pfx_q.addr_ovr;
            end
            LMAC_MODE_OFF: begin
                rd_mux[LMAC_MODE_SUB_LSB +: 2] = mode_q.submode;
                rd_mux[LMAC_MODE_DADDR_LSB +: 2] = mode_q.def_addr;
                rd_mux[LMAC_MODE_DOP_LSB +: 2] = mode_q.def_op;
                rd_mux[LMAC_MODE_EADDR_LSB +: 2] = mode_q.eff_addr;
                rd_mux[LMAC_MODE_EOP_LSB +: 2] = mode_q.eff_op;
                rd_mux[LMAC_MODE_RSVD_BIT] = mode_q.rsvd;
                rd_mux[LMAC_MODE_F64_BIT] = f64_q;
            end
            LMAC_FAULT_OFF: begin
                rd_mux[LMAC_FLT_STICKY_BIT] = sticky_q;
                rd_mux[LMAC_FLT_REFUSED_BIT] = refused_q;
                rd_mux[LMAC_FLT_CNT_LSB +: 8] = cnt_q;
                rd_mux[LMAC_FLT_CODE_LSB +: 16] = LMAC_GP_ERROR_CODE;
            end
            LMAC_TBL_OFF: begin
                rd_mux[LMAC_TBL_COUNT-1:0] = tbl_q;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data captured in the request cycle, valid while ack is high
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dat_q <= '0;
        end else if (req & ~ack_q & ~wb_we_i) begin
            dat_q <= rd_mux;
        end
    end

    // Control bits and active flag; a failed check leaves both as they were
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= lmac_ctrl_t'(LMAC_CTRL_RST);
            lma_q <= 1'b0;
        end else begin
            if (wr_ctrl & ~chk_fail) begin // RL10
                ctrl_q <= ctrl_new;
            end
            lma_q <= lma_d; // RL15
        end
    end

    // Code-segment attributes and current prefixes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cs_q <= lmac_cs_t'(LMAC_CS_RST);
            pfx_q <= lmac_pfx_t'(LMAC_PFX_RST);
        end else begin
            if (wr_cs) begin
                cs_q.long_attr <= wb_sel_i[0] ? wb_dat_i[LMAC_CS_L_BIT] : cs_q.long_attr;
                cs_q.def_size <= wb_sel_i[0] ? wb_dat_i[LMAC_CS_D_BIT] : cs_q.def_size;
            end
            if (wr_pfx & wb_sel_i[0]) begin
                pfx_q.op_ovr <= wb_dat_i[LMAC_PFX_OPSZ_BIT];
                pfx_q.op64 <= wb_dat_i[LMAC_PFX_W_BIT];
                pfx_q.addr_ovr <= wb_dat_i[LMAC_PFX_ADSZ_BIT];
            end
        end
    end

    // Upper half of the page base can only be reached once long mode is active
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ptb_q <= LMAC_PTB_RST;
        end else begin
            if (wr_lo) begin
                ptb_q[31:0] <= lane_merge(ptb_q[31:0], wb_dat_i, wb_sel_i); // RL19
            end
            if (wr_hi & lma_q) begin
                ptb_q[63:32] <= lane_merge(ptb_q[63:32], wb_dat_i, wb_sel_i); // RL2
            end
        end
    end

    // Table pointers read as legacy on activation and leaving; reload marks accepted only when active
    assign refuse = (wr_hi | wr_tbl) & ~lma_q; // RL2

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tbl_q <= '0;
        end else if (activate | deactivate) begin
            tbl_q <= '0; // RL16
        end else if (wr_tbl & lma_q & wb_sel_i[0]) begin
            tbl_q <= tbl_q | wb_dat_i[LMAC_TBL_COUNT-1:0]; // RL16
        end
    end

    // Fault pulse, sticky status and saturating count; a new event beats a clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gp_q <= 1'b0;
            sticky_q <= 1'b0;
            refused_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            gp_q <= wr_ctrl & chk_fail; // RL10
            if (wr_ctrl & chk_fail) begin
                sticky_q <= 1'b1;
            end else if (wr_flt & wb_sel_i[0] & wb_dat_i[LMAC_FLT_STICKY_BIT]) begin
                sticky_q <= 1'b0;
            end
            if (refuse) begin
                refused_q <= 1'b1;
            end else if (wr_flt & wb_sel_i[0] & wb_dat_i[LMAC_FLT_REFUSED_BIT]) begin
                refused_q <= 1'b0;
            end
            if (wr_ctrl & chk_fail & (cnt_q != LMAC_CNT_MAX)) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    lmac_mode_decode u_decode (
        .active(lma_q),
        .cs(cs_q),
        .pfx(pfx_q),
        .mode(mode_d)
    );

    // Mode outputs registered so every port except the constant gp_error_code leaves a flip-flop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_q <= '0;
            f64_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            f64_q <= lma_q; // RL2
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign long_mode_active_flag = lma_q;
    assign feat64_allowed = f64_q;
    assign mode_o = mode_q;
    assign page_table_base_reg = ptb_q;
    assign general_protection_fault = gp_q;
    assign gp_error_code = LMAC_GP_ERROR_CODE;

endmodule

// *** lmac_long_mode_ctrl_checker.sv ***
// Port-level assertions for the long-mode activation control block
`timescale 1ns/1ps
module lmac_long_mode_ctrl_checker
    import lmac_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic long_mode_active_flag,
    input wire logic feat64_allowed,
    input wire lmac_mode_t mode_o,
    input wire logic [63:0] page_table_base_reg,
    input wire logic general_protection_fault,
    input wire logic [15:0] gp_error_code
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic ctrl_wr;
    assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == LMAC_CTRL_OFF;
    sequence req_taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_one_pulse: assert property (req_taken_s |=> ack_pulse_s) else $error("ack not a single pulse");
    a_fault_from_ctrl: assert property (general_protection_fault |-> $past(ctrl_wr))
        else $error("fault without control write");
    a_fault_pulse_short: assert property (general_protection_fault |=> !general_protection_fault)
        else $error("fault longer than one cycle");
    a_fault_keeps_flag: assert property (general_protection_fault |-> $stable(long_mode_active_flag))
        else $error("faulting write moved active flag");
    a_rise_needs_paging: assert property ($rose(long_mode_active_flag) |->
        $past(ctrl_wr && wb_dat_i[LMAC_PG_BIT] && wb_dat_i[LMAC_LME_BIT]))
        else $error("activation without paging and enable");
    a_fall_on_pg_off: assert property ($fell(long_mode_active_flag) |->
        $past(ctrl_wr && !wb_dat_i[LMAC_PG_BIT]))
        else $error("deactivation without paging cleared");
    a_feat_lags_flag: assert property (feat64_allowed == $past(long_mode_active_flag))
        else $error("feature flag out of step");
    a_gp_code_zero: assert property (gp_error_code == LMAC_GP_ERROR_CODE)
        else $error("fault code not zero");
    a_long64_sizes: assert property (mode_o.submode == LMAC_SUB_LONG64 |->
        mode_o.def_addr == LMAC_SZ64 && mode_o.def_op == LMAC_SZ32 && !mode_o.rsvd)
        else $error("wrong 64-bit default sizes");
    a_legacy_when_off: assert property (mode_o.submode != LMAC_SUB_LEGACY |-> $past(long_mode_active_flag))
        else $error("long submode while inactive");
    a_narrow_sizes: assert property (mode_o.submode inside {LMAC_SUB_LEGACY, LMAC_SUB_COMPAT} |->
        mode_o.def_addr == mode_o.def_op && mode_o.def_op != LMAC_SZ64 && mode_o.eff_op != LMAC_SZ64)
        else $error("wrong legacy or compat sizes");
    a_rsvd_marked: assert property (mode_o.rsvd == (mode_o.submode == LMAC_SUB_RSVD))
        else $error("reserved marker mismatch");
    a_ptb_hi_held: assert property (!long_mode_active_flag |=> $stable(page_table_base_reg[63:32]))
        else $error("upper base changed while inactive");
endmodule

bind lmac_long_mode_ctrl lmac_long_mode_ctrl_checker u_chk (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .long_mode_active_flag(long_mode_active_flag), .feat64_allowed(feat64_allowed), .mode_o(mode_o),
    .page_table_base_reg(page_table_base_reg), .general_protection_fault(general_protection_fault),
    .gp_error_code(gp_error_code));

// *** lmac_long_mode_ctrl_bench.sv ***
// Self-checking bench for the long-mode activation control block
`timescale 1ns/1ps
module lmac_long_mode_ctrl_bench;
    import lmac_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic long_mode_active_flag;
    logic feat64_allowed;
    lmac_mode_t mode_o;
    logic [63:0] page_table_base_reg;
    logic general_protection_fault;
    logic [15:0] gp_error_code;
    int bad_count = 0;
    int num_checks = 0;
    int gp_seen = 0;
    int gp_exp = 0;
    logic lme, pg, phys_addr_extension, lma;
    logic [1:0] cs;
    logic [2:0] pfx;
    logic [63:0] ptb;
    logic [31:0] rd;
    logic [7:0] fcnt;
    logic refd;
    logic [3:0] tbl;
    // Identity mapping and interrupt masking are software duties; the bench raises no interrupts
    // Walks the activation order enable, base, extensions, then paging, with the fault cases before and after activation
    localparam logic [39:0] CORNER [23] = '{
        40'h00_00000001, 40'h08_12345000, 40'h0c_0000dead,
        40'h00_00000003, 40'h04_00000001, 40'h00_00000007,
        40'h04_00000000, 40'h00_00000005, 40'h00_00000007,
        40'h0c_00000009, 40'h1c_00000005, 40'h04_00000002, 40'h04_00000001,
        40'h10_00000001, 40'h10_00000003, 40'h10_00000004,
        40'h04_00000003, 40'h00_00000006, 40'h00_00000003,
        40'h00_00000005, 40'h00_00000004, 40'h00_00000006,
        40'h20_00000007};
    localparam logic [7:0] ADRS [7] = '{LMAC_CTRL_OFF, LMAC_CS_OFF, LMAC_PTB_LO_OFF, LMAC_PTB_HI_OFF,
        LMAC_PFX_OFF, LMAC_TBL_OFF, 8'h20};

    lmac_long_mode_ctrl u_dut (
        .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .long_mode_active_flag(long_mode_active_flag), .feat64_allowed(feat64_allowed), .mode_o(mode_o),
        .page_table_base_reg(page_table_base_reg), .general_protection_fault(general_protection_fault),
        .gp_error_code(gp_error_code));

    always #4 clock = ~clock;

    // Counting pulses avoids sampling the one-cycle fault at an exact edge
    always @(posedge clock) begin
        if (general_protection_fault === 1'b1) gp_seen++;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask

    function automatic lmac_mode_t exp_mode(logic a, logic [1:0] c, logic [2:0] p);
        lmac_mode_t m;
        m = '0;
        if (!a || !c[0]) begin
            m.submode = a ? LMAC_SUB_COMPAT : LMAC_SUB_LEGACY;
            m.def_addr = c[1] ? LMAC_SZ32 : LMAC_SZ16;
            m.def_op = m.def_addr;
            m.eff_addr = (c[1] ^ p[2]) ? LMAC_SZ32 : LMAC_SZ16;
            m.eff_op = (c[1] ^ p[0]) ? LMAC_SZ32 : LMAC_SZ16;
        end else if (c[1]) begin
            m = '{LMAC_SUB_RSVD, LMAC_SZ32, LMAC_SZ32, LMAC_SZ32, LMAC_SZ32, 1'b1};
        end else begin
            m.submode = LMAC_SUB_LONG64;
            m.def_addr = LMAC_SZ64;
            m.def_op = LMAC_SZ32;
            m.eff_addr = p[2] ? LMAC_SZ32 : LMAC_SZ64;
            m.eff_op = p[1] ? LMAC_SZ64 : (p[0] ? LMAC_SZ16 : LMAC_SZ32);
        end
        return m;
    endfunction

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        {lme, pg, phys_addr_extension, lma, cs, pfx, ptb, fcnt, refd, tbl} = '0;
        @(posedge clock);
        chk(long_mode_active_flag, 1'b0);
    endtask

    // Checks use old paging and active state with the new enable and extension bits
    task automatic step(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic f;
        bus(1'b1, a, d, r);
        case (a)
            LMAC_CTRL_OFF: begin
                f = (pg && d[0] != lme) || (!pg && d[1] && d[0] && (!d[2] || cs[0])) || (phys_addr_extension && !d[2] && lma);
                if (f) begin
                    gp_exp++;
                    if (fcnt != LMAC_CNT_MAX) fcnt++;
                end else begin
                    // Table reload marks fall back to legacy on activation and on leaving
                    if (!pg && d[1] && d[0]) {lma, tbl} = 5'h10;
                    if (pg && !d[1] && lma) {lma, tbl} = 5'h00;
                    {phys_addr_extension, pg, lme} = d[2:0];
                end
            end
            LMAC_CS_OFF: cs = d[1:0];
            LMAC_PFX_OFF: pfx = d[2:0];
            LMAC_PTB_LO_OFF: ptb[31:0] = d;
            LMAC_PTB_HI_OFF: begin
                if (lma) ptb[63:32] = d;
                else refd = 1'b1;
            end
            LMAC_TBL_OFF: begin
                if (lma) tbl = tbl | d[3:0];
                else refd = 1'b1;
            end
            default: ;
        endcase
        repeat (2) @(posedge clock);
        chk(long_mode_active_flag, lma);
        chk(feat64_allowed, lma);
        chk(mode_o, exp_mode(lma, cs, pfx));
        chk(gp_seen, gp_exp);
        chk(page_table_base_reg, ptb);
        bus(1'b0, LMAC_CTRL_OFF, 32'h0, r);
        chk(r, {28'h0, lma, phys_addr_extension, pg, lme});
        bus(1'b0, LMAC_FAULT_OFF, 32'h0, r);
        chk(r, {LMAC_GP_ERROR_CODE, fcnt, 6'h00, refd, fcnt != 8'h00});
        bus(1'b0, LMAC_TBL_OFF, 32'h0, r);
        chk(r, {28'h0, tbl});
    endtask

    initial begin
        void'($urandom(32'h32e94576));
        do_reset();
        foreach (CORNER[i]) step(CORNER[i][39:32], CORNER[i][31:0]);
        bus(1'b0, 8'h20, 32'h0, rd);
        chk(rd, 32'h0);
        do_reset();
        repeat (400) step(ADRS[$urandom_range(6)], $urandom);
        give_verdict();
    end

    initial begin
        repeat (50000) @(posedge clock);
        bad_count++;
        give_verdict();
    end
endmodule
